// File: disf_pkg.sv
`default_nettype none

package disf_pkg;

  // Register window placement on the system bus
  localparam logic [31:0] BASE_ADDR = 32'hA000_0000;
  localparam int DECODE_LSB = 8;
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CLEAR = 8'h04;

  // Reset values of the two registers
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] CLEAR_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Channel count and per-channel flag layout
  localparam int NUM_CH = 8;
  localparam int FLAGS_PER_CH = 4;
  localparam int BIT_ANY = 0;
  localparam int BIT_COMPLETE = 1;
  localparam int BIT_HALFWAY = 2;
  localparam int BIT_ERROR = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // Bus transfer encodings
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;
  localparam logic HRESP_ERROR = 1'h1;

  // Reset synchroniser depth
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] SYNC_CLEAR = 2'h0;

  // Bus response sequencer, one-hot
  typedef enum logic [2:0] {
    DISF_RESP_OKAY = 3'h1,
    DISF_RESP_ERR_WAIT = 3'h2,
    DISF_RESP_ERR_DONE = 3'h4
  } disf_resp_t;

endpackage

`default_nettype wire

// File: disf_reset_sync.sv
`default_nettype none

module disf_reset_sync (
  // Clock and raw reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Released reset
  output logic reset_n_o
);

  typedef struct packed {
    logic [disf_pkg::SYNC_STAGES-1:0] stage; // Shift chain of ones
  } disf_sync_state_t;

  disf_sync_state_t state;
  disf_sync_state_t next_state;

  // Shift a one in; only the last stage is looked at
  always_comb begin
    next_state = state;
    next_state.stage = {state.stage[disf_pkg::SYNC_STAGES-2:0], 1'b1};
  end

  // Assert at once, release only after two clean edges
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state.stage <= disf_pkg::SYNC_CLEAR;
    end else begin
      state <= next_state;
    end
  end

  assign reset_n_o = state.stage[disf_pkg::SYNC_STAGES-1];

endmodule

`default_nettype wire

// File: disf_chan_flags.sv
`default_nettype none

module disf_chan_flags (
  // Clock, reset and freeze
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Event pulses from the channel engine
  input wire logic complete_evt_i,
  input wire logic halfway_evt_i,
  input wire logic error_evt_i,
  // Clear strobe, one bit per flag
  input wire logic [3:0] clear_i,
  // Sticky flags of this channel
  output logic [3:0] flags_o
);

  typedef struct packed {
    logic [3:0] flags; // Any, complete, halfway, error
  } disf_chan_state_t;

  disf_chan_state_t state;
  disf_chan_state_t next_state;
  logic [3:0] set_vec; // Flags raised this cycle

  // Build the set vector and merge it with the clear
  always_comb begin
    set_vec = '0;
    set_vec[disf_pkg::BIT_COMPLETE] = complete_evt_i;
    set_vec[disf_pkg::BIT_HALFWAY] = halfway_evt_i;
    set_vec[disf_pkg::BIT_ERROR] = error_evt_i;
    // Any of the three events also raises the summary flag
    set_vec[disf_pkg::BIT_ANY] =
      complete_evt_i | halfway_evt_i | error_evt_i;
    next_state = state;
    // Zero in the clear keeps a flag; a set beats a clear
    next_state.flags = (state.flags & ~clear_i) | set_vec;
  end

  // Flags hold while the clock enable is low
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state.flags <= disf_pkg::FLAGS_RESET;
    end else if (clk_en_i) begin
      state <= next_state;
    end
  end

  assign flags_o = state.flags;

endmodule

`default_nettype wire

// File: disf_top.sv
// Functional notes
// - Registers decoded at fixed base address
// - Status register read-only, resets to zero
// - Clear register write-only, resets to zero
// - Channel zero flags at bits 0..3
// - Channel one flags at bits 4..7
// - Channel two flags at bits 8..11
// - Channel three flags at bits 12..15
// - Channel four flags at bits 16..19
// - Channel four error flag at bit 19
// - Same pattern up to channel seven
// - Hardware sets flags; they stay set
// - Writing one clears matching status bit
// - Summary flag set by any channel event
// - Complete flag set when transfer finishes
// - Halfway flag set at half transfer
// - Error flag set on bus error
// - Error disables channel and sets flag
// - Interrupt only when its enable is set

`default_nettype none

module disf_top (
  // Clock, reset and freeze
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Register bus, slave side
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Event pulses from the channel engines
  input wire logic [7:0] complete_evt_i,
  input wire logic [7:0] halfway_evt_i,
  input wire logic [7:0] error_evt_i,
  // Interrupt enables from each channel_config_reg
  input wire logic [7:0] complete_irq_enable_i,
  input wire logic [7:0] halfway_irq_enable_i,
  input wire logic [7:0] error_irq_enable_i,
  // Per-channel interrupt and enable-clear request
  output logic [7:0] channel_irq_o,
  output logic [7:0] channel_disable_o
);

  // Whole registered state of the bus side
  typedef struct packed {
    disf_pkg::disf_resp_t resp; // Response sequencer
    logic clear_pending; // Data phase of a clear write
    logic [31:0] rdata; // Read data for the data phase
    logic [7:0] irq; // Gated interrupt lines
    logic [7:0] disable_req; // Enable-clear pulses
  } disf_top_state_t;

  disf_top_state_t state;
  disf_top_state_t next_state;

  logic rst_n; // Released reset for the whole block
  logic [31:0] status_vec; // Flags gathered in register layout
  logic [31:0] clear_vec; // Clear strobe from the bus
  logic addr_phase; // Valid transfer offered to us
  logic in_window; // Address lies in our window
  logic size_ok; // Only whole-word access allowed
  logic [7:0] offset; // Byte offset inside the window
  logic [7:0] any_flag; // Summary flags per channel
  logic [7:0] complete_flag; // Complete flags per channel
  logic [7:0] halfway_flag; // Halfway flags per channel
  logic [7:0] error_flag; // Error flags per channel

  // Reset enters asynchronously and leaves through two flops
  disf_reset_sync u_reset_sync (
    .clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .reset_n_o(rst_n)
  );

  // One flag group per channel, packed four bits apart
  for (genvar ch = 0; ch < disf_pkg::NUM_CH; ch++) begin : g_chan
    logic [3:0] flags; // Flags of this channel

    disf_chan_flags u_flags (
      .clk_i(ref_clk_i),
      .reset_n_i(rst_n),
      .clk_en_i(clk_en_i),
      .complete_evt_i(complete_evt_i[ch]),
      .halfway_evt_i(halfway_evt_i[ch]),
      .error_evt_i(error_evt_i[ch]),
      // Clear bits use the very positions of the status bits
      .clear_i(clear_vec[ch*disf_pkg::FLAGS_PER_CH +:
                         disf_pkg::FLAGS_PER_CH]),
      .flags_o(flags)
    );

    // Channel n occupies bits 4n to 4n+3
    assign status_vec[ch*disf_pkg::FLAGS_PER_CH +:
                      disf_pkg::FLAGS_PER_CH] = flags;
    assign any_flag[ch] = flags[disf_pkg::BIT_ANY];
    assign complete_flag[ch] = flags[disf_pkg::BIT_COMPLETE];
    assign halfway_flag[ch] = flags[disf_pkg::BIT_HALFWAY];
    assign error_flag[ch] = flags[disf_pkg::BIT_ERROR];
  end

  // Address phase decode
  // A transfer counts only when selected, active and the bus is ready
  assign addr_phase = hsel_i & htrans_i[disf_pkg::HTRANS_ACTIVE_BIT] &
                      hready_i;
  // Upper address bits must match the fixed base
  assign in_window = haddr_i[31:disf_pkg::DECODE_LSB] ==
                     disf_pkg::BASE_ADDR[31:disf_pkg::DECODE_LSB];
  assign offset = haddr_i[disf_pkg::DECODE_LSB-1:0];
  // Byte and halfword accesses are faulted, not half done
  assign size_ok = hsize_i == disf_pkg::HSIZE_WORD;

  // Clear strobe is live only in the data phase of a clear write.
  // Bits written as zero leave their flags alone.
  assign clear_vec = state.clear_pending ? hwdata_i :
                     disf_pkg::CLEAR_RESET;

  // Next-state logic for the bus side and the outputs
  always_comb begin
    next_state = state;
    next_state.clear_pending = 1'b0;
    next_state.rdata = disf_pkg::READ_ZERO;

    // Response sequencer: an error takes two cycles on the bus
    unique case (state.resp)
      disf_pkg::DISF_RESP_OKAY: begin
        if (addr_phase && in_window && !size_ok) begin
          // Wrong size: answer with a two-cycle error
          next_state.resp = disf_pkg::DISF_RESP_ERR_WAIT;
        end else if (addr_phase && in_window && hwrite_i) begin
          // Only the clear offset has a write effect.
          // Writes to the status offset change nothing.
          next_state.clear_pending =
            offset == disf_pkg::OFF_CLEAR;
        end else if (addr_phase && in_window) begin
          // Reads: status shows the flags, all else reads zero
          if (offset == disf_pkg::OFF_STATUS) begin
            next_state.rdata = status_vec;
          end else begin
            // Write-only clear register reads as zero
            next_state.rdata = disf_pkg::READ_ZERO;
          end
        end
      end
      disf_pkg::DISF_RESP_ERR_WAIT: begin
        // First error cycle holds the bus
        next_state.resp = disf_pkg::DISF_RESP_ERR_DONE;
      end
      disf_pkg::DISF_RESP_ERR_DONE: begin
        // Second error cycle releases the bus; a new transfer
        // may be offered here, and is taken normally
        next_state.resp = disf_pkg::DISF_RESP_OKAY;
        if (addr_phase && in_window && !size_ok) begin
          next_state.resp = disf_pkg::DISF_RESP_ERR_WAIT;
        end else if (addr_phase && in_window && hwrite_i) begin
          next_state.clear_pending =
            offset == disf_pkg::OFF_CLEAR;
        end else if (addr_phase && in_window &&
                     offset == disf_pkg::OFF_STATUS) begin
          next_state.rdata = status_vec;
        end
      end
      default: begin
        // Illegal code: fall back to a clean idle answer
        next_state.resp = disf_pkg::DISF_RESP_OKAY;
      end
    endcase

    // Interrupt per channel, each cause gated by its own enable.
    // Taken from the flags, so it stays up until software clears.
    next_state.irq = (complete_flag & complete_irq_enable_i) |
                     (halfway_flag & halfway_irq_enable_i) |
                     (error_flag & error_irq_enable_i);

    // A bus error on a channel asks the config logic to drop its
    // enable bit; the error flag itself is raised in the group.
    next_state.disable_req = error_evt_i;
  end

  // Register the whole state; the clock enable freezes it all
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state.resp <= disf_pkg::DISF_RESP_OKAY;
      state.clear_pending <= 1'b0;
      state.rdata <= disf_pkg::STATUS_RESET;
      state.irq <= '0;
      state.disable_req <= '0;
    end else if (clk_en_i) begin
      state <= next_state;
    end
  end

  // Bus answer
  // Wait state only in the first error cycle
  assign hreadyout_o = state.resp != disf_pkg::DISF_RESP_ERR_WAIT;
  assign hresp_o = (state.resp == disf_pkg::DISF_RESP_OKAY) ?
                   disf_pkg::HRESP_OKAY : disf_pkg::HRESP_ERROR;
  // Read data comes straight from a flop, captured at the
  // address phase; events landing on that edge show next read
  assign hrdata_o = state.rdata;

  // Channel side outputs
  assign channel_irq_o = state.irq;
  assign channel_disable_o = state.disable_req;

endmodule

`default_nettype wire

// File: disf_asserts.sv
`default_nettype none

module disf_asserts (
  // Clock, reset and freeze
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Register bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Events, enables and channel outputs
  input wire logic [7:0] error_evt_i,
  input wire logic [7:0] complete_irq_enable_i,
  input wire logic [7:0] halfway_irq_enable_i,
  input wire logic [7:0] error_irq_enable_i,
  input wire logic [7:0] channel_irq_o,
  input wire logic [7:0] channel_disable_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  // Address phase accepted, and whether it hits the register window
  logic take;
  logic in_win;
  logic word;
  logic [7:0] en_any;
  logic [7:0] err_en;
  assign take = hsel_i && htrans_i[1] && hready_i && clk_en_i;
  assign in_win = haddr_i[31:8] == 24'hA0_0000;
  assign word = hsize_i == disf_pkg::HSIZE_WORD;
  // No enable at all means no interrupt may come out
  assign en_any = complete_irq_enable_i | halfway_irq_enable_i |
                  error_irq_enable_i;
  assign err_en = error_evt_i & error_irq_enable_i;

  AST_WORD_OKAY: assert property (take && in_win && word |=>
    hreadyout_o && !hresp_o) else $error("word access not okay");
  AST_SIZE_ERR: assert property (take && in_win && !word |=>
    !hreadyout_o && hresp_o ##1 hreadyout_o && hresp_o)
    else $error("bad size not answered with two-cycle error");
  AST_OUTSIDE: assert property (take && !in_win |=>
    hreadyout_o && !hresp_o && hrdata_o == 32'h0000_0000)
    else $error("access outside window not ignored");
  AST_CLR_READ: assert property (take && in_win && !hwrite_i &&
    haddr_i[7:0] == 8'h04 |=> hrdata_o == 32'h0000_0000)
    else $error("clear register read back nonzero");
  AST_RD_IDLE: assert property (clk_en_i && !(take && !hwrite_i)
    |=> hrdata_o == 32'h0000_0000) else $error("read data not idle");
  AST_DIS_PULSE: assert property (clk_en_i |=>
    channel_disable_o == $past(error_evt_i))
    else $error("disable pulse does not follow error event");
  AST_IRQ_MASK: assert property (clk_en_i && en_any == 8'h00
    |=> channel_irq_o == 8'h00) else $error("masked interrupt raised");
  AST_IRQ_ERR: assert property (clk_en_i && err_en != 8'h00 ##1
    clk_en_i && $stable(error_irq_enable_i) |=>
    (channel_irq_o & $past(err_en, 2)) == $past(err_en, 2))
    else $error("enabled error event raised no interrupt");
endmodule

bind disf_top disf_asserts u_chk (.ref_clk_i, .reset_n_i, .clk_en_i,
  .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hready_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .error_evt_i,
  .complete_irq_enable_i, .halfway_irq_enable_i, .error_irq_enable_i,
  .channel_irq_o, .channel_disable_o);

`default_nettype wire

// File: dma_irq_status_flags_bench.sv
`default_nettype none

module dma_irq_status_flags_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] STS = 32'hA000_0000;
  localparam logic [31:0] CLR = 32'hA000_0004;
  localparam logic [31:0] ONES = 32'hFFFF_FFFF;
  // Clock, reset and bus drive, named as the ports they feed
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0000_0000;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0000_0000;
  logic hready_i = 1'b1;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  // Channel events, enables and outputs
  logic [7:0] complete_evt_i = 8'h00;
  logic [7:0] halfway_evt_i = 8'h00;
  logic [7:0] error_evt_i = 8'h00;
  logic [7:0] complete_irq_enable_i = 8'h00;
  logic [7:0] halfway_irq_enable_i = 8'h00;
  logic [7:0] error_irq_enable_i = 8'h00;
  logic [7:0] channel_irq_o;
  logic [7:0] channel_disable_o;
  // Last data-phase result
  logic [31:0] rd;
  logic rsp;
  int errors = 0;
  int total_checks = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  disf_top DUT (.ref_clk_i, .reset_n_i, .clk_en_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o,
    .hreadyout_o, .hresp_o, .complete_evt_i, .halfway_evt_i,
    .error_evt_i, .complete_irq_enable_i, .halfway_irq_enable_i,
    .error_irq_enable_i, .channel_irq_o, .channel_disable_o);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One transfer; data and response are taken while ready is high
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [2:0] sz, input logic [31:0] d);
    @(posedge ref_clk_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    hsize_i <= sz;
    @(posedge ref_clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    #1;
    // Error answers add one wait cycle; more would be a hang
    for (int n = 0; n < 3 && hreadyout_o !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    rd = hrdata_o;
    rsp = hresp_o;
    @(posedge ref_clk_i);
  endtask

  // Read the status register and compare
  task automatic sts(input logic [31:0] exp);
    xfer(STS, 1'b0, 3'h2, 32'h0000_0000);
    check(rd, exp);
  endtask

  // One-cycle event pulses, raised on a rising edge
  task automatic pulse(input logic [7:0] c, h, e);
    @(posedge ref_clk_i);
    complete_evt_i <= c;
    halfway_evt_i <= h;
    error_evt_i <= e;
    @(posedge ref_clk_i);
    complete_evt_i <= 8'h00;
    halfway_evt_i <= 8'h00;
    error_evt_i <= 8'h00;
  endtask

  // Every kind on every channel sets its bit and the summary bit
  task automatic t_map();
    logic [7:0] b;
    for (int ch = 0; ch < 8; ch++) begin
      for (int k = 1; k < 4; k++) begin
        b = 8'h01 << ch;
        pulse(k == 1 ? b : 8'h00, k == 2 ? b : 8'h00, k == 3 ? b : 8'h00);
        sts((32'h1 << (4 * ch)) | (32'h1 << (4 * ch + k)));
        xfer(CLR, 1'b1, 3'h2, ONES);
        sts(32'h0000_0000);
      end
    end
  endtask

  // Sticky flags survive ignored writes; summary cleared on its own
  task automatic t_sticky();
    error_irq_enable_i <= 8'h04;
    pulse(8'h00, 8'h20, 8'h04);
    #1;
    check(32'(channel_disable_o), 32'h0000_0004);
    @(posedge ref_clk_i);
    #1;
    check(32'(channel_irq_o), 32'h0000_0004);
    xfer(CLR, 1'b1, 3'h2, 32'h0000_0000);
    sts(32'h0050_0900);
    xfer(STS, 1'b1, 3'h2, ONES);
    sts(32'h0050_0900);
    xfer(CLR, 1'b1, 3'h1, ONES);
    check(32'(rsp), 32'h0000_0001);
    xfer(32'hA000_0104, 1'b1, 3'h2, ONES);
    sts(32'h0050_0900);
    xfer(CLR, 1'b1, 3'h2, 32'h0000_0100);
    sts(32'h0050_0800);
    xfer(CLR, 1'b1, 3'h2, ONES);
    error_irq_enable_i <= 8'h00;
    sts(32'h0000_0000);
  endtask

  // An event on the clearing edge wins over the clear
  task automatic t_setwins();
    fork
      xfer(CLR, 1'b1, 3'h2, 32'h0000_0003);
      begin
        @(posedge ref_clk_i);
        pulse(8'h01, 8'h00, 8'h00);
      end
    join
    sts(32'h0000_0003);
  endtask

  // Complete and halfway causes gated per channel, a frozen clock
  // drops events, and a reset in mid-run wipes every flag
  task automatic t_gate_freeze();
    complete_irq_enable_i <= 8'h02;
    halfway_irq_enable_i <= 8'h80;
    pulse(8'h03, 8'h80, 8'h00);
    @(posedge ref_clk_i);
    #1;
    // Channel zero has no enable, so only channels one and seven
    check(32'(channel_irq_o), 32'h0000_0082);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    pulse(8'h00, 8'h00, 8'h10);
    #1;
    check(32'(channel_disable_o), 32'h0000_0000);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    sts(32'h5000_0033);
    complete_irq_enable_i <= 8'h00;
    halfway_irq_enable_i <= 8'h00;
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    check(32'(channel_irq_o), 32'h0000_0000);
    sts(32'h0000_0000);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sts(32'h0000_0000);
    xfer(CLR, 1'b0, 3'h2, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    t_map();
    t_sticky();
    t_setwins();
    xfer(CLR, 1'b1, 3'h2, ONES);
    t_gate_freeze();
    tally_and_finish();
  end

  // Watchdog, sized well above the roughly 340 cycles of the tests
  initial begin
    repeat (4000) @(posedge ref_clk_i);
    errors++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
